// ### asa_pkg.sv
// Constants and types shared by the arithmetic and shift datapath
package asa_pkg;
	localparam int APB_AW = 8;
	localparam int DATA_W = 8;
	// Register byte addresses
	localparam logic [APB_AW-1:0] ADDR_CMD = 8'h00;
	localparam logic [APB_AW-1:0] ADDR_WREG = 8'h04;
	localparam logic [APB_AW-1:0] ADDR_FLAGS = 8'h08;
	localparam logic [APB_AW-1:0] ADDR_RAM_BASE = 8'h40;
	// Command word fields
	localparam int CMD_W = 24;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_OP_W = 5;
	localparam int CMD_IDX_LSB = 8;
	localparam int CMD_DEST_BIT = 15;
	localparam int CMD_IMM_LSB = 16;
	// Flag positions
	localparam int FLAGS_W = 4;
	localparam int FLG_NULL = 0;
	localparam int FLG_WRAP = 1;
	localparam int FLG_HALF = 2;
	localparam int FLG_SIGNED = 3;
	// Reset values
	localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
	localparam logic [FLAGS_W-1:0] FLAGS_RESET = 4'h0;
	localparam logic [CMD_W-1:0] CMD_RESET = 24'h000000;

	typedef enum logic [CMD_OP_W-1:0] {
		OP_ADD_I, OP_ADD_M, OP_ADDC_M, OP_ADDC_1, OP_SUB_I, OP_SUB_M, OP_SUB_REV,
		OP_SUBC_A, OP_SUBC_M, OP_SUBC_1, OP_INC, OP_DEC, OP_CLEAR,
		OP_SRZ, OP_SRC, OP_SLZ, OP_SLC, OP_SWAP
	} asa_op_t;

	typedef enum logic [2:0] {
		K_NONE, K_ARITH, K_SHIFT, K_CLEAR, K_SWAP
	} asa_kind_t;
endpackage

// ### asa_adder8.sv
// Eight-bit adder with nibble carry and signed overflow outputs
`timescale 1ns/1ns
module asa_adder8 import asa_pkg::*; (
	input wire logic [DATA_W-1:0] op_a,
	input wire logic [DATA_W-1:0] op_b,
	input wire logic carry_in,
	output logic [DATA_W-1:0] sum,
	output logic carry_out,
	output logic half_out,
	output logic ovf_out
);
	logic [4:0] low;
	logic [4:0] high;

	assign low = {1'h0, op_a[3:0]} + {1'h0, op_b[3:0]} + {4'h0, carry_in};
	assign high = {1'h0, op_a[7:4]} + {1'h0, op_b[7:4]} + {4'h0, low[4]};
	assign sum = {high[3:0], low[3:0]};
	assign carry_out = high[4];
	assign half_out = low[4];
	assign ovf_out = (op_a[7] == op_b[7]) && (sum[7] != op_a[7]);
endmodule // asa_adder8

// ### asa_alu.sv
// Arithmetic and shift datapath with working register, data RAM and APB access
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module asa_alu import asa_pkg::*; #(
	parameter int RAM_DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	localparam int IDX_W = $clog2(RAM_DEPTH);
	localparam logic [APB_AW-1:0] RAM_END = APB_AW'(ADDR_RAM_BASE + 4 * RAM_DEPTH);

	logic [DATA_W-1:0] working_register;
	logic [FLAGS_W-1:0] flags;
	logic [CMD_W-1:0] cmd_reg;
	logic [DATA_W-1:0] ram [RAM_DEPTH];

	// APB handshake: one wait state, outputs registered
	wire access = psel && penable;
	wire first_access = access && !pready;
	wire done = access && pready;
	wire hit_cmd = (paddr == ADDR_CMD);
	wire hit_wreg = (paddr == ADDR_WREG);
	wire hit_flags = (paddr == ADDR_FLAGS);
	wire hit_ram = (paddr >= ADDR_RAM_BASE) && (paddr < RAM_END) && (paddr[1:0] == 2'h0);
	wire addr_hit = hit_cmd || hit_wreg || hit_flags || hit_ram;
	wire [APB_AW-1:0] ram_off = paddr - ADDR_RAM_BASE;
	wire [IDX_W-1:0] bus_idx = ram_off[IDX_W+1:2];
	wire bus_wr = done && pwrite && addr_hit;
	wire exec = bus_wr && hit_cmd;

	// Command fields, taken straight from the write data at the executing edge
	wire [CMD_OP_W-1:0] op_code = pwdata[CMD_OP_LSB +: CMD_OP_W];
	wire asa_op_t op = asa_op_t'(op_code);
	wire [IDX_W-1:0] exec_idx = pwdata[CMD_IDX_LSB +: IDX_W];
	wire dest_ram = pwdata[CMD_DEST_BIT];
	wire [DATA_W-1:0] imm = pwdata[CMD_IMM_LSB +: DATA_W];
	wire [DATA_W-1:0] mem = ram[exec_idx];
	wire wrap_in = flags[FLG_WRAP];

	logic [DATA_W-1:0] opx;
	logic [DATA_W-1:0] opy;
	logic carry_raw;
	logic is_sub;
	logic to_ram;
	asa_kind_t kind;

	always_comb begin
		opx = working_register;
		opy = 8'h00;
		carry_raw = 1'h0;
		is_sub = 1'h0;
		to_ram = 1'h0;
		kind = K_ARITH;
		unique case (op)
			OP_ADD_I: begin
				opy = imm;
			end
			OP_ADD_M: begin
				opy = mem;
				to_ram = dest_ram;
			end
			OP_ADDC_M: begin
				opy = mem;
				carry_raw = wrap_in;
				to_ram = dest_ram;
			end
			OP_ADDC_1: begin
				opx = dest_ram ? mem : working_register;
				carry_raw = wrap_in;
				to_ram = dest_ram;
			end
			OP_SUB_I: begin
				opy = imm;
				is_sub = 1'h1;
			end
			OP_SUB_M: begin
				opy = mem;
				is_sub = 1'h1;
			end
			OP_SUB_REV: begin
				opx = mem;
				opy = working_register;
				is_sub = 1'h1;
				to_ram = 1'h1;
			end
			OP_SUBC_A: begin
				opy = mem;
				carry_raw = wrap_in;
				is_sub = 1'h1;
			end
			OP_SUBC_M: begin
				opx = mem;
				opy = working_register;
				carry_raw = wrap_in;
				is_sub = 1'h1;
				to_ram = 1'h1;
			end
			OP_SUBC_1: begin
				opx = dest_ram ? mem : working_register;
				carry_raw = wrap_in;
				is_sub = 1'h1;
				to_ram = dest_ram;
			end
			OP_INC: begin
				opx = mem;
				opy = 8'h01;
				to_ram = 1'h1;
			end
			OP_DEC: begin
				opx = mem;
				opy = 8'h01;
				is_sub = 1'h1;
				to_ram = 1'h1;
			end
			OP_CLEAR: begin
				kind = K_CLEAR;
				to_ram = 1'h1;
			end
			OP_SRZ, OP_SRC, OP_SLZ, OP_SLC: begin
				opx = dest_ram ? mem : working_register;
				kind = K_SHIFT;
				to_ram = dest_ram;
			end
			OP_SWAP: begin
				kind = K_SWAP;
			end
			default: begin
				kind = K_NONE;
			end
		endcase
	end

	// Subtraction adds the inverted subtrahend; borrow is the inverted carry
	wire [DATA_W-1:0] add_b = is_sub ? ~opy : opy;
	wire add_cin = is_sub ? ~carry_raw : carry_raw;
	logic [DATA_W-1:0] sum;
	logic c8;
	logic c4;
	logic ovf;

	asa_adder8 u_adder (
		.op_a(opx),
		.op_b(add_b),
		.carry_in(add_cin),
		.sum(sum),
		.carry_out(c8),
		.half_out(c4),
		.ovf_out(ovf)
	);

	wire shift_right = (op == OP_SRZ) || (op == OP_SRC);
	wire shift_in = ((op == OP_SRC) || (op == OP_SLC)) ? wrap_in : 1'h0;
	wire [DATA_W-1:0] shift_res = shift_right ? {shift_in, opx[7:1]} : {opx[6:0], shift_in};
	wire shift_out = shift_right ? opx[0] : opx[7];

	wire [FLAGS_W-1:0] arith_flags;
	assign arith_flags[FLG_NULL] = (sum == 8'h00);
	assign arith_flags[FLG_WRAP] = is_sub ? ~c8 : c8;
	assign arith_flags[FLG_HALF] = is_sub ? ~c4 : c4;
	assign arith_flags[FLG_SIGNED] = ovf;

	wire [DATA_W-1:0] result =
		(kind == K_ARITH) ? sum :
		(kind == K_SHIFT) ? shift_res :
		(kind == K_SWAP) ? {working_register[3:0], working_register[7:4]} : 8'h00;

	wire exec_live = exec && (kind != K_NONE);
	wire exec_ram = exec_live && to_ram;
	wire exec_wreg = exec_live && !to_ram;

	wire [FLAGS_W-1:0] shift_flags = {flags[3:2], shift_out, flags[0]};
	wire [FLAGS_W-1:0] next_flags =
		(exec && kind == K_ARITH) ? arith_flags :
		(exec && kind == K_SHIFT) ? shift_flags :
		(bus_wr && hit_flags) ? pwdata[FLAGS_W-1:0] : flags;

	wire [DATA_W-1:0] next_wreg =
		exec_wreg ? result :
		(bus_wr && hit_wreg) ? pwdata[DATA_W-1:0] : working_register;

	wire ram_we = exec_ram || (bus_wr && hit_ram);
	wire [IDX_W-1:0] ram_wi = exec_ram ? exec_idx : bus_idx;
	wire [DATA_W-1:0] ram_wd = exec_ram ? result : pwdata[DATA_W-1:0];

	wire [31:0] rd_value =
		hit_cmd ? {8'h00, cmd_reg} :
		hit_wreg ? {24'h000000, working_register} :
		hit_flags ? {28'h0000000, flags} :
		hit_ram ? {24'h000000, ram[bus_idx]} : 32'h00000000;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pready <= 1'h0;
			pslverr <= 1'h0;
			prdata <= 32'h00000000;
		end else begin
			pready <= first_access;
			pslverr <= first_access && !addr_hit;
			if (first_access) begin
				prdata <= rd_value;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			working_register <= WREG_RESET;
			flags <= FLAGS_RESET;
			cmd_reg <= CMD_RESET;
		end else begin
			working_register <= next_wreg;
			flags <= next_flags;
			if (exec) begin
				cmd_reg <= pwdata[CMD_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < RAM_DEPTH; i++) begin
				ram[i] <= 8'h00;
			end
		end else if (ram_we) begin
			ram[ram_wi] <= ram_wd;
		end
	end

	// Helper for checks: the RAM byte at the index field of the write data one cycle earlier
	logic [IDX_W-1:0] chk_idx;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			chk_idx <= '0;
		end else begin
			chk_idx <= exec_idx;
		end
	end
	wire [DATA_W-1:0] chk_byte = ram[chk_idx];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_add_imm_sum: assert property (
		exec && op == OP_ADD_I |=>
			working_register == 8'($past(working_register) + $past(imm)))
		else $error("add immediate result wrong");

	a_add_imm_wrap: assert property (
		exec && op == OP_ADD_I |=>
			flags[FLG_WRAP] == ((9'($past(working_register)) + 9'($past(imm))) > 9'h0FF))
		else $error("add immediate wrap out wrong");

	a_addc_ram_dest: assert property (
		exec && op == OP_ADDC_M && dest_ram |=>
			chk_byte == 8'($past(working_register) + $past(mem) + 8'($past(wrap_in)))
			&& $stable(working_register))
		else $error("add with carry into RAM wrong");

	a_sub_borrow_flag: assert property (
		exec && op == OP_SUB_I |=>
			flags[FLG_WRAP] == ($past(working_register) < $past(imm))
			&& working_register == 8'($past(working_register) - $past(imm)))
		else $error("subtract borrow wrong");

	a_subc_rev_ram: assert property (
		exec && op == OP_SUBC_M |=>
			chk_byte == 8'($past(mem) - $past(working_register) - 8'($past(wrap_in))))
		else $error("reverse subtract with borrow wrong");

	a_inc_ram_byte: assert property (
		exec && op == OP_INC |=> chk_byte == 8'($past(mem) + 8'h01)
			&& flags[FLG_NULL] == (chk_byte == 8'h00))
		else $error("increment wrong");

	a_clear_keeps_flags: assert property (
		exec && op == OP_CLEAR |=> chk_byte == 8'h00 && $stable(flags))
		else $error("clear wrong");

	a_srz_wreg: assert property (
		exec && op == OP_SRZ && !dest_ram |=>
			working_register == {1'h0, $past(working_register[7:1])}
			&& flags[FLG_WRAP] == $past(working_register[0])
			&& flags[FLG_NULL] == $past(flags[FLG_NULL])
			&& flags[3:2] == $past(flags[3:2]))
		else $error("right shift wrong");

	a_slc_rotate: assert property (
		exec && op == OP_SLC && !dest_ram |=>
			working_register == {$past(working_register[6:0]), $past(wrap_in)}
			&& flags[FLG_WRAP] == $past(working_register[7]))
		else $error("rotate left wrong");

	a_swap_nibbles: assert property (
		exec && op == OP_SWAP |=>
			working_register == {$past(working_register[3:0]), $past(working_register[7:4])}
			##0 $stable(flags))
		else $error("swap wrong");

	a_add_ram_wreg: assert property (
		exec && op == OP_ADD_M && !dest_ram |=>
			working_register == 8'($past(working_register) + $past(mem))
			&& flags[FLG_WRAP] == ((9'($past(working_register)) + 9'($past(mem))) > 9'h0FF))
		else $error("add to working register wrong");

	a_half_wrap_add: assert property (
		exec && op == OP_ADD_I |=>
			flags[FLG_HALF] == (({1'h0, $past(working_register[3:0])}
			+ {1'h0, $past(imm[3:0])}) > 5'h0F))
		else $error("half wrap on add wrong");

	a_sub_rev_ram: assert property (
		exec && op == OP_SUB_REV |=>
			chk_byte == 8'($past(mem) - $past(working_register))
			&& flags[FLG_WRAP] == ($past(mem) < $past(working_register)))
		else $error("reverse subtract wrong");

	a_dec_ram_byte: assert property (
		exec && op == OP_DEC |=>
			chk_byte == 8'($past(mem) - 8'h01)
			&& flags[FLG_WRAP] == ($past(mem) == 8'h00))
		else $error("decrement wrong");

	a_src_ram_rotate: assert property (
		exec && op == OP_SRC && dest_ram |=>
			chk_byte == {$past(wrap_in), $past(mem[7:1])}
			&& flags[FLG_WRAP] == $past(mem[0])
			&& $stable(working_register))
		else $error("rotate right of RAM byte wrong");

	a_slz_wreg: assert property (
		exec && op == OP_SLZ && !dest_ram |=>
			working_register == {$past(working_register[6:0]), 1'h0}
			&& flags[FLG_WRAP] == $past(working_register[7])
			&& flags[FLG_NULL] == $past(flags[FLG_NULL]))
		else $error("left shift wrong");
endmodule // asa_alu

// ### test_arith_shift_alu.sv
// Self-checking bench for the arithmetic and shift datapath
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
	$display("unexpected %s expected %0h seen %0h", what, exp, got); end end
module test_arith_shift_alu import asa_pkg::*;;
	logic clk = 0;
	logic reset_n = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [APB_AW-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	int errors = 0;
	int samples_checked = 0;
	logic [33:0] notes[$];

	asa_alu asa_alu_inst (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	initial begin
		forever #25 clk = ~clk;
	end

	task automatic summarize();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One APB transfer; the expected answer is queued before the request
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
		int n;
		notes.push_back({~wr, err, d});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			$display("unexpected pready expected 1 seen %0b", pready);
			summarize();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Oldest note is matched against each completed transfer
	always @(posedge clk) begin
		logic [33:0] nt;
		if (pready === 1'b1) begin
			if (notes.size() == 0) begin
				errors++;
				$display("unexpected answer expected none seen %0h", prdata);
			end else begin
				nt = notes.pop_front();
				`CHECK("pslverr", nt[32], pslverr)
				if (nt[33])
					`CHECK("prdata", nt[31:0], prdata)
			end
		end
	end

	// Returns {memory target, flags, result}
	function automatic logic [12:0] model(input int op, input logic [7:0] w, m, im,
		input logic [3:0] f, input logic dst);
		logic [7:0] x, y, r;
		logic [3:0] fo;
		logic c, ci, co, h, v, s, ar, t;
		c = f[FLG_WRAP];
		t = dst;
		x = dst ? m : w;
		y = 8'h00;
		ci = 1'b0;
		s = 1'b0;
		ar = 1'b1;
		fo = f;
		r = x;
		case (op)
			0: begin t = 0; x = w; y = im; end
			1: begin x = w; y = m; end
			2: begin x = w; y = m; ci = c; end
			3: ci = c;
			4: begin t = 0; x = w; y = im; s = 1; end
			5: begin t = 0; x = w; y = m; s = 1; end
			6: begin t = 1; x = m; y = w; s = 1; end
			7: begin t = 0; x = w; y = m; s = 1; ci = c; end
			8: begin t = 1; x = m; y = w; s = 1; ci = c; end
			9: begin s = 1; ci = c; end
			10: begin t = 1; x = m; y = 8'h01; end
			11: begin t = 1; x = m; y = 8'h01; s = 1; end
			default: ar = 0;
		endcase
		if (ar && s) begin
			r = x - y - ci;
			co = {1'b0, x} < {1'b0, y} + ci;
			h = {1'b0, x[3:0]} < {1'b0, y[3:0]} + ci;
			v = (x[7] != y[7]) && (r[7] != x[7]);
			fo = {v, h, co, r == 8'h00};
		end else if (ar) begin
			{co, r} = {1'b0, x} + {1'b0, y} + ci;
			h = ({1'b0, x[3:0]} + {1'b0, y[3:0]} + ci) > 5'h0F;
			v = (x[7] == y[7]) && (r[7] != x[7]);
			fo = {v, h, co, r == 8'h00};
		end else begin
			case (op)
				12: begin t = 1; r = 8'h00; end
				13: begin r = {1'b0, x[7:1]}; fo[FLG_WRAP] = x[0]; end
				14: begin r = {c, x[7:1]}; fo[FLG_WRAP] = x[0]; end
				15: begin r = {x[6:0], 1'b0}; fo[FLG_WRAP] = x[7]; end
				16: begin r = {x[6:0], c}; fo[FLG_WRAP] = x[7]; end
				17: begin t = 0; r = {w[3:0], w[7:4]}; end
				default: begin t = 0; r = w; end
			endcase
		end
		return {t, fo, r};
	endfunction

	// One command with its operands, then read back the working register, the flags and the RAM byte
	task automatic run_op(input int op, input logic [7:0] w, m, im, input logic [3:0] f, i,
		input logic dst);
		logic [7:0] ra;
		logic [12:0] e;
		ra = ADDR_RAM_BASE + {2'b00, i, 2'b00};
		e = model(op, w, m, im, f, dst);
		apb(1, ADDR_WREG, {24'h0, w}, 0);
		apb(1, ADDR_FLAGS, {28'h0, f}, 0);
		apb(1, ra, {24'h0, m}, 0);
		apb(1, ADDR_CMD, 32'(op) | (32'(i) << CMD_IDX_LSB) | (32'(dst) << CMD_DEST_BIT)
			| (32'(im) << CMD_IMM_LSB), 0);
		apb(0, ADDR_WREG, {24'h0, e[12] ? w : e[7:0]}, 0);
		apb(0, ADDR_FLAGS, {28'h0, e[11:8]}, 0);
		apb(0, ra, {24'h0, e[12] ? e[7:0] : m}, 0);
	endtask

	initial begin
		logic [7:0] w, m, im;
		logic [3:0] f, i;
		logic dst;
		logic [7:0] dw[3];
		logic [7:0] dm[3];
		logic [3:0] df[3];
		dw = '{8'hFF, 8'h80, 8'h00};
		dm = '{8'h01, 8'h01, 8'h00};
		df = '{4'hF, 4'h0, 4'h2};
		void'($urandom(10));
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		apb(0, ADDR_WREG, 32'h0, 0);
		apb(0, ADDR_FLAGS, 32'h0, 0);
		apb(0, ADDR_CMD, 32'h0, 0);
		apb(0, ADDR_RAM_BASE + 8'h3C, 32'h0, 0);
		apb(1, 8'h0C, 32'h5A, 1);
		apb(0, 8'h41, 32'h0, 1);
		for (int rep = 0; rep < 6; rep++) begin
			for (int op = 0; op < 19; op++) begin
				w = (rep < 3) ? dw[rep] : 8'($urandom);
				m = (rep < 3) ? dm[rep] : 8'($urandom);
				f = (rep < 3) ? df[rep] : 4'($urandom);
				im = (rep < 3) ? dm[rep] : 8'($urandom);
				i = 4'($urandom);
				dst = (op inside {6, 8, 10, 11, 12}) ? 1'b1 : 1'($urandom);
				if (op inside {0, 4, 5, 7, 17})
					dst = 1'b0;
				run_op(op, w, m, im, f, i, dst);
			end
		end
		// Carry and borrow out of a RAM byte, and a rotate acting on RAM
		run_op(10, 8'h00, 8'hFF, 8'h00, 4'h0, 4'h1, 1'b1);
		run_op(11, 8'h00, 8'h00, 8'h00, 4'h0, 4'h2, 1'b1);
		run_op(14, 8'h00, 8'h81, 8'h00, 4'h2, 4'h3, 1'b1);
		repeat (3) @(posedge clk);
		if (notes.size() != 0) begin
			errors++;
			$display("unexpected notes left expected 0 seen %0d", notes.size());
		end
		summarize();
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("unexpected timeout expected end seen %0d cycles", 20000);
		summarize();
	end
endmodule // test_arith_shift_alu
